/* File: mgmt_host_model.sv */
`timescale 1ns/10ps
// Behavioural host controller on the two-wire management bus.
module mgmt_host_model (
  input  wire logic clk,
  input  wire logic sdaOut,
  input  wire logic sdaOe,
  output logic      scl,
  output wire logic sdaIn
);

  // Quarter bit in clk cycles; SCL low lasts two quarters, above the 8-clk
  // minimum, so the device has settled its bit before SCL rises.
  localparam int Q = 5;

  logic hostSda;

  // Open-drain wire with a pull-up: released lines read high, never stale.
  assign sdaIn = hostSda & (sdaOe ? sdaOut : 1'b1);

  // Both lines idle high from time zero.
  initial begin
    scl = 1'b1;
    hostSda = 1'b1;
  end

  ////////////////////////////////////////
  // Bit level sequences, all paced on the falling edge of clk.
  task automatic quarter();
    repeat (Q) @(negedge clk);
  endtask : quarter

  // Start or repeated start: SDA falls while SCL is high.
  task automatic start();
    quarter();
    hostSda = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    hostSda = 1'b0;
    quarter();
    scl = 1'b0;
  endtask : start

  // Stop: SDA rises while SCL is high.
  task automatic stop();
    quarter();
    hostSda = 1'b0;
    quarter();
    scl = 1'b1;
    quarter();
    hostSda = 1'b1;
    quarter();
  endtask : stop

  // One clock pulse; the wire is sampled in the middle of SCL high.
  task automatic bit_io(input logic b, output logic s);
    quarter();
    hostSda = b;
    quarter();
    scl = 1'b1;
    quarter();
    s = sdaIn;
    quarter();
    scl = 1'b0;
  endtask : bit_io

  // Eight bits MSB first, then the device's acknowledge bit.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack);
  endtask : send_byte

  // Eight bits released to the device, then our ack (high on the last).
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, s);
  endtask : recv_byte

endmodule : mgmt_host_model

/* File: mgmt_map_pkg.sv */
package mgmt_map_pkg;

  // Two-wire bus address of the management map (A0h in 8-bit form).
  localparam logic [6:0] DEV_ADDR       = 7'h50;

  // Lower page layout.
  localparam logic [7:0] FLAG_FIRST     = 8'h03;
  localparam logic [7:0] FLAG_LAST      = 8'h15;
  localparam int         FLAG_COUNT     = 19;
  localparam logic [7:0] CTRL_FIRST     = 8'h56;
  localparam logic [7:0] PAGE_SEL_ADDR  = 8'h7F;

  // Upper page layout.
  localparam logic [7:0] CC_ADDR        = 8'hBF;
  localparam logic [7:0] BASE_PAGE      = 8'h00;
  localparam logic [5:0] CC_LAST_IDX    = 6'h3E;
  localparam logic [9:0] CC_PHYS_BASE   = 10'h080;
  localparam logic [1:0] VS_PAGE        = 2'h3;
  localparam logic [7:0] VS_FIRST       = 8'hE2;

  // Physical storage: lower page, then four upper pages of 128 bytes.
  localparam int         MEM_AW         = 10;
  localparam int         MEM_DW         = 8;
  localparam int         MEM_DEPTH      = 1024;
  localparam logic [2:0] UPPER_OFFSET   = 3'h1;
  localparam logic [9:0] FLAG_FIRST_PHY = 10'h003;
  localparam logic [9:0] FLAG_LAST_PHY  = 10'h015;

  // Serial bit counting.
  localparam logic [3:0] BIT_LAST       = 4'h7;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [3:0] BIT_FIRST_TX   = 4'h1;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_DEV   = 7'h02,
    ST_WADDR = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK   = 7'h10,
    ST_RDATA = 7'h20,
    ST_HACK  = 7'h40
  } i2cState_t;

endpackage : mgmt_map_pkg

/* File: mgmt_mem_if.sv */
`timescale 1ns/10ps
interface mgmt_mem_if;
  import mgmt_map_pkg::*;
  logic              wrEn;
  logic [MEM_AW-1:0] wrAddr;
  logic [MEM_DW-1:0] wrData;
  logic [MEM_AW-1:0] rdAddr;
  logic [MEM_DW-1:0] rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr,
                input rdData);
  modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr,
                output rdData);
endinterface : mgmt_mem_if

/* File: mgmt_mem_ram.sv */
`timescale 1ns/10ps
module mgmt_mem_ram
  import mgmt_map_pkg::*;
(
  input wire logic clk,
  mgmt_mem_if.mem  bus
);

  logic [MEM_DW-1:0] store [0:MEM_DEPTH-1];

  // Storage carries no reset; content is loaded by the module side.
  always_ff @(posedge clk) begin
    if (bus.wrEn) begin
      store[bus.wrAddr] <= bus.wrData;
    end
    bus.rdData <= store[bus.rdAddr];
  end

endmodule : mgmt_mem_ram

/* File: module_mgmt_memory_map.sv */
`timescale 1ns/10ps
// Functional notes
// - One always-visible 128-byte lower page, upper pages above it.
// - The page-select byte at 127 picks the upper page shown.
// - The device answers on bus address A0h for every access.
// - A flag pulls the interrupt low, and the host then reads the flags.
// - All interrupt data sits in the lower page for one read.
// - Bytes 0 to 81 are read-only: identifier, status, flags, monitors.
// - Controls 86-97, masks 100-106, spares 98-99, 107-118 are R/W.
// - Bytes 123-126 form a read/write password entry area.
// - Bytes 119-122 form a read/write password change area.
// - Page zero byte 191 holds a check code over bytes 128 to 190.
module module_mgmt_memory_map
  import mgmt_map_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              scl,
  input  wire logic              sdaIn,
  output wire logic              sdaOut,
  output wire logic              sdaOe,
  output wire logic              interruptRequestN,
  input  wire logic              monClk,
  input  wire logic              monWrEn,
  input  wire logic [MEM_AW-1:0] monAddr,
  input  wire logic [MEM_DW-1:0] monData,
  output wire logic              monReady
);

  logic [2:0]        sclSync_ff, sdaSync_ff, reqSync_ff, ackSync_ff;
  logic              sclQ_ff, sdaQ_ff, sclPrev_ff, sdaPrev_ff;
  logic              sclRise, sclFall, startCond, stopCond;
  i2cState_t         state_ff, afterAck_ff;
  logic [7:0]        rxShift_ff, txShift_ff, txByte, addr_ff, pageSel_ff;
  logic [3:0]        bitCnt_ff;
  logic              byteDone_ff, sdaOe_ff, sdaOut_ff, intReqN_ff;
  logic              dataByte, addrByte, rdByteEnd, loadTx;
  logic              isFlag, hostWritable, anyFlag;
  logic [4:0]        flagIdx, monFlagIdx;
  logic [7:0]        flag_ff [0:FLAG_COUNT-1];
  logic              hostWrPend_ff, monStrobe, monIsFlag, monWrMem;
  logic [MEM_AW-1:0] hostWrAddr_ff, hostPhys, monAddrHold_ff;
  logic [MEM_DW-1:0] hostWrData_ff, monDataHold_ff;
  logic [2:0]        pagePlus;
  logic [5:0]        scanIdx_ff, lagIdx_ff;
  logic              scanValid_ff;
  logic [7:0]        scanSum_ff, ccBase_ff, ccNext;
  logic              monReqTog_ff, monAckQ_ff, monReady_ff, reqQ_ff;
  logic              reqSeen_ff;

  mgmt_mem_if memBus ();

  mgmt_mem_ram uRam (
    .clk (clk),
    .bus (memBus)
  );

  assign sdaOut            = sdaOut_ff;
  assign sdaOe             = sdaOe_ff;
  assign interruptRequestN = intReqN_ff;
  assign monReady          = monReady_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once the second and third stages agree,
  // which also rejects single-sample glitches on the slow bus lines.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclSync_ff <= 3'h7;
      sdaSync_ff <= 3'h7;
      sclQ_ff    <= 1'h1;
      sdaQ_ff    <= 1'h1;
      sclPrev_ff <= 1'h1;
      sdaPrev_ff <= 1'h1;
      sdaOut_ff  <= 1'h0;
    end else begin
      sclSync_ff <= {sclSync_ff[1:0], scl};
      sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
      if (sclSync_ff[1] == sclSync_ff[2]) sclQ_ff <= sclSync_ff[2];
      if (sdaSync_ff[1] == sdaSync_ff[2]) sdaQ_ff <= sdaSync_ff[2];
      sclPrev_ff <= sclQ_ff;
      sdaPrev_ff <= sdaQ_ff;
      sdaOut_ff  <= 1'h0;                      // Open drain: only pulls low.
    end
  end

  // Bus events and the decoded byte-level strobes.
  assign sclRise   = sclQ_ff & ~sclPrev_ff;
  assign sclFall   = ~sclQ_ff & sclPrev_ff;
  assign startCond = sclQ_ff & sclPrev_ff & sdaPrev_ff & ~sdaQ_ff;
  assign stopCond  = sclQ_ff & sclPrev_ff & ~sdaPrev_ff & sdaQ_ff;
  assign addrByte  = (state_ff == ST_WADDR) & sclFall & byteDone_ff;
  assign dataByte  = (state_ff == ST_WDATA) & sclFall & byteDone_ff;
  assign rdByteEnd = (state_ff == ST_RDATA) & sclFall &
                     (bitCnt_ff == BYTE_BITS);
  assign loadTx    = sclFall & (((state_ff == ST_ACK) &
                     (afterAck_ff == ST_RDATA)) | (state_ff == ST_HACK));

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and the byte handed to the host on a read.
  assign pagePlus = 3'(pageSel_ff[1:0]) + UPPER_OFFSET;
  assign hostPhys = addr_ff[7] ? {pagePlus, addr_ff[6:0]}
                               : {3'h0, addr_ff[6:0]};
  assign isFlag   = (addr_ff >= FLAG_FIRST) && (addr_ff <= FLAG_LAST);
  assign flagIdx  = 5'(addr_ff - FLAG_FIRST);
  // Controls, masks, password areas and reserved bytes are plain RAM.
  assign hostWritable =
    (!addr_ff[7] && addr_ff >= CTRL_FIRST && addr_ff < PAGE_SEL_ADDR) ||
    (addr_ff[7] && pageSel_ff[1:0] == VS_PAGE && addr_ff >= VS_FIRST);

  always_comb begin
    txByte = memBus.rdData;
    if (isFlag) begin
      txByte = flag_ff[flagIdx];
    end else if (addr_ff == PAGE_SEL_ADDR) begin
      txByte = pageSel_ff;
    end else if (addr_ff == CC_ADDR && pageSel_ff == BASE_PAGE) begin
      txByte = ccBase_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave state machine, clocked from the oversampled bus lines.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      afterAck_ff <= ST_IDLE;
      rxShift_ff  <= 8'h00;
      txShift_ff  <= 8'h00;
      bitCnt_ff   <= 4'h0;
      byteDone_ff <= 1'h0;
      sdaOe_ff    <= 1'h0;
    end else if (startCond) begin
      state_ff    <= ST_DEV;
      bitCnt_ff   <= 4'h0;
      byteDone_ff <= 1'h0;
      sdaOe_ff    <= 1'h0;
    end else if (stopCond) begin
      state_ff <= ST_IDLE;
      sdaOe_ff <= 1'h0;
    end else begin
      case (state_ff)
        ST_DEV, ST_WADDR, ST_WDATA: begin
          if (sclRise) begin
            rxShift_ff  <= {rxShift_ff[6:0], sdaQ_ff};
            bitCnt_ff   <= bitCnt_ff + 4'h1;
            byteDone_ff <= (bitCnt_ff == BIT_LAST);
          end else if (sclFall && byteDone_ff) begin
            byteDone_ff <= 1'h0;
            bitCnt_ff   <= 4'h0;
            if (state_ff == ST_DEV && rxShift_ff[7:1] != DEV_ADDR) begin
              state_ff <= ST_IDLE;
            end else begin
              sdaOe_ff <= 1'h1;
              state_ff <= ST_ACK;
              if (state_ff != ST_DEV) afterAck_ff <= ST_WDATA;
              else if (rxShift_ff[0]) afterAck_ff <= ST_RDATA;
              else afterAck_ff <= ST_WADDR;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            state_ff <= afterAck_ff;
            sdaOe_ff <= (afterAck_ff == ST_RDATA) ? ~txByte[7] : 1'h0;
            if (afterAck_ff == ST_RDATA) begin
              txShift_ff <= {txByte[6:0], 1'h0};
              bitCnt_ff  <= BIT_FIRST_TX;
            end
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            if (bitCnt_ff == BYTE_BITS) begin
              sdaOe_ff <= 1'h0;
              state_ff <= ST_HACK;
            end else begin
              sdaOe_ff   <= ~txShift_ff[7];
              txShift_ff <= {txShift_ff[6:0], 1'h0};
              bitCnt_ff  <= bitCnt_ff + 4'h1;
            end
          end
        end
        ST_HACK: begin
          // A not-acknowledge ends the read; the host then sends a stop.
          if (sclRise && sdaQ_ff) begin
            state_ff <= ST_IDLE;
          end else if (sclFall) begin
            sdaOe_ff   <= ~txByte[7];
            txShift_ff <= {txByte[6:0], 1'h0};
            bitCnt_ff  <= BIT_FIRST_TX;
            state_ff   <= ST_RDATA;
          end
        end
        ST_IDLE: begin
          sdaOe_ff <= 1'h0;
        end
        default: begin
          state_ff <= ST_IDLE;
          sdaOe_ff <= 1'h0;
        end
      endcase
    end
  end

  // Byte address with auto-increment, and the page-select byte.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff    <= 8'h00;
      pageSel_ff <= BASE_PAGE;
    end else begin
      if (addrByte) addr_ff <= rxShift_ff;
      else if (dataByte || rdByteEnd) addr_ff <= addr_ff + 8'h01;
      if (dataByte && addr_ff == PAGE_SEL_ADDR) begin
        pageSel_ff <= rxShift_ff;
      end
    end
  end

  // Host writes wait one slot when a module-side write holds the port.
  // Bytes below the control area are acknowledged and then dropped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hostWrPend_ff <= 1'h0;
      hostWrAddr_ff <= '0;
      hostWrData_ff <= 8'h00;
    end else if (dataByte && hostWritable) begin
      hostWrPend_ff <= 1'h1;
      hostWrAddr_ff <= hostPhys;
      hostWrData_ff <= rxShift_ff;
    end else if (!monWrMem) begin
      hostWrPend_ff <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags: a module event setting a bit wins over a host read that
  // clears it in the same cycle, so no event is lost.
  assign monIsFlag  = (monAddrHold_ff >= FLAG_FIRST_PHY) &&
                      (monAddrHold_ff <= FLAG_LAST_PHY);
  assign monFlagIdx = 5'(monAddrHold_ff - FLAG_FIRST_PHY);
  assign monWrMem   = monStrobe & ~monIsFlag;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < FLAG_COUNT; i++) flag_ff[i] <= 8'h00;
    end else begin
      for (int i = 0; i < FLAG_COUNT; i++) begin
        flag_ff[i] <=
          ((loadTx && isFlag && flagIdx == 5'(i)) ? 8'h00 : flag_ff[i]) |
          ((monStrobe && monIsFlag && monFlagIdx == 5'(i)) ?
            monDataHold_ff : 8'h00);
      end
    end
  end

  always_comb begin
    anyFlag = 1'h0;
    for (int i = 0; i < FLAG_COUNT; i++) anyFlag = anyFlag | (|flag_ff[i]);
  end

  // Interrupt line stays low while any flag byte is non-zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) intReqN_ff <= 1'h1;
    else intReqN_ff <= ~anyFlag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Check-code scanner borrows the read port while the bus is idle, so a
  // new identification byte shows up in the code within two passes.
  assign ccNext = scanSum_ff + memBus.rdData;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scanIdx_ff   <= 6'h00;
      lagIdx_ff    <= 6'h00;
      scanValid_ff <= 1'h0;
      scanSum_ff   <= 8'h00;
      ccBase_ff    <= 8'h00;
    end else begin
      scanValid_ff <= (state_ff == ST_IDLE);
      lagIdx_ff    <= scanIdx_ff;
      if (state_ff == ST_IDLE) begin
        scanIdx_ff <= (scanIdx_ff == CC_LAST_IDX) ? 6'h00 : scanIdx_ff + 6'h01;
      end
      if (scanValid_ff && lagIdx_ff == CC_LAST_IDX) begin
        ccBase_ff  <= ccNext;
        scanSum_ff <= 8'h00;
      end else if (scanValid_ff) begin
        scanSum_ff <= ccNext;
      end
    end
  end

  // Memory port steering; module-side writes take priority.
  assign memBus.wrEn   = monWrMem | hostWrPend_ff;
  assign memBus.wrAddr = monWrMem ? monAddrHold_ff : hostWrAddr_ff;
  assign memBus.wrData = monWrMem ? monDataHold_ff : hostWrData_ff;
  assign memBus.rdAddr = (state_ff == ST_IDLE) ?
                         (CC_PHYS_BASE + 10'(scanIdx_ff)) : hostPhys;

  ////////////////////////////////////////////////////////////////////////////
  // Module-side write port on its own clock; a toggle handshake carries each
  // word across, and the held data stay still until the echo returns.
  always_ff @(posedge monClk or negedge rst_n) begin
    if (!rst_n) begin
      monReqTog_ff   <= 1'h0;
      monAddrHold_ff <= '0;
      monDataHold_ff <= 8'h00;
      ackSync_ff     <= 3'h0;
      monAckQ_ff     <= 1'h0;
      monReady_ff    <= 1'h0;
    end else begin
      ackSync_ff <= {ackSync_ff[1:0], reqSeen_ff};
      if (ackSync_ff[1] == ackSync_ff[2]) monAckQ_ff <= ackSync_ff[2];
      if (monWrEn && monReady_ff) begin
        monReqTog_ff   <= ~monReqTog_ff;
        monAddrHold_ff <= monAddr;
        monDataHold_ff <= monData;
        monReady_ff    <= 1'h0;
      end else begin
        monReady_ff <= (monAckQ_ff == monReqTog_ff);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqSync_ff <= 3'h0;
      reqQ_ff    <= 1'h0;
      reqSeen_ff <= 1'h0;
    end else begin
      reqSync_ff <= {reqSync_ff[1:0], monReqTog_ff};
      if (reqSync_ff[1] == reqSync_ff[2]) reqQ_ff <= reqSync_ff[2];
      reqSeen_ff <= reqQ_ff;
    end
  end
  assign monStrobe = reqQ_ff ^ reqSeen_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks; all of them live on the system clock and sleep during reset.
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence hostDataByte;
    dataByte;
  endsequence

  sequence flagEvent;
    monStrobe && monIsFlag && (monDataHold_ff != 8'h00);
  endsequence

  chk_ack_on_write: assert property (
    hostDataByte |=> sdaOe_ff && state_ff == ST_ACK)
    else $error("write byte not acknowledged");

  chk_ro_dropped: assert property (
    hostDataByte and (!addr_ff[7] && addr_ff < CTRL_FIRST) |=>
    !hostWrPend_ff)
    else $error("read-only byte was queued for writing");

  chk_ctrl_stored: assert property (
    hostDataByte and (!addr_ff[7] && addr_ff >= CTRL_FIRST &&
    addr_ff < PAGE_SEL_ADDR) |=> hostWrPend_ff &&
    hostWrData_ff == $past(rxShift_ff) ##[1:2] !hostWrPend_ff)
    else $error("control byte write not committed");

  chk_page_select: assert property (
    hostDataByte and (addr_ff == PAGE_SEL_ADDR) |=>
    pageSel_ff == $past(rxShift_ff))
    else $error("page select not updated");

  chk_upper_mapping: assert property (
    state_ff != ST_IDLE && addr_ff[7] |->
    memBus.rdAddr[9:7] == 3'(pageSel_ff[1:0]) + UPPER_OFFSET &&
    memBus.rdAddr[6:0] == addr_ff[6:0])
    else $error("upper page mapped to wrong storage");

  chk_flag_interrupt: assert property (
    flagEvent |-> ##2 !intReqN_ff)
    else $error("flag event did not raise interrupt");

  chk_flag_clear: assert property (
    loadTx && isFlag && !(monStrobe && monIsFlag) |=>
    flag_ff[$past(flagIdx)] == 8'h00)
    else $error("flag byte not cleared by read");

  chk_cc_readback: assert property (
    loadTx && addr_ff == CC_ADDR && pageSel_ff == BASE_PAGE |=>
    txShift_ff == {$past(ccBase_ff[6:0]), 1'h0} &&
    sdaOe_ff == !$past(ccBase_ff[7]))
    else $error("check code not returned at its byte");

  chk_dev_address: assert property (
    state_ff == ST_DEV && sclFall && byteDone_ff &&
    rxShift_ff[7:1] != DEV_ADDR |=> state_ff == ST_IDLE && !sdaOe_ff)
    else $error("foreign bus address acknowledged");

endmodule : module_mgmt_memory_map

/* File: module_mgmt_memory_map_tb.sv */
`timescale 1ns/10ps
module module_mgmt_memory_map_tb;
  import mgmt_map_pkg::*;

  localparam int LIMIT = 70000;

  logic              clk;
  logic              rst_n;
  logic              scl;
  logic              sdaIn;
  logic              sdaOut;
  logic              sdaOe;
  logic              interruptRequestN;
  logic              monClk;
  logic              monWrEn;
  logic [MEM_AW-1:0] monAddr;
  logic [MEM_DW-1:0] monData;
  logic              monReady;
  logic [7:0]        rdBuf [0:31];
  logic [7:0]        sum;
  logic [7:0]        expByte;
  logic              ack;
  int                errors;
  int                compares;
  int                cycles;
  int                n;
  int                rwAddr [12] = '{86, 97, 98, 99, 100, 106, 107, 118,
                                     119, 122, 123, 126};
  int                roAddr [4] = '{0, 2, 22, 81};

  module_mgmt_memory_map u_dut (.clk(clk), .rst_n(rst_n), .scl(scl),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .interruptRequestN(interruptRequestN), .monClk(monClk),
    .monWrEn(monWrEn), .monAddr(monAddr), .monData(monData),
    .monReady(monReady));

  mgmt_host_model u_host (.clk(clk), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .scl(scl), .sdaIn(sdaIn));

  // Two unrelated clocks: 40 ns system, 32 ns module side.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    monClk = 1'b0;
    #7;
    forever #16 monClk = ~monClk;
  end

  ////////////////////////////////////////
  // Checking, verdict and the hang guard.
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // A run that outlives the longest expected sequence is a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////
  // Access tasks for both ports.
  task automatic mon_wr(input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    do begin
      @(negedge monClk);
      k++;
    end while (monReady !== 1'b1 && k < 200);
    monAddr = a;
    monData = d;
    monWrEn = 1'b1;
    @(negedge monClk);
    monWrEn = 1'b0;
    @(negedge monClk);
  endtask : mon_wr

  // Every byte of a write must be acknowledged, read-only targets too.
  task automatic hw(input logic [7:0] a, input logic [7:0] d);
    logic [2:0] acks;
    u_host.start();
    u_host.send_byte({DEV_ADDR, 1'b0}, acks[2]);
    u_host.send_byte(a, acks[1]);
    u_host.send_byte(d, acks[0]);
    u_host.stop();
    check("write acks", {5'h00, acks}, 8'h00);
  endtask : hw

  // Sequential read of cnt bytes into rdBuf after a repeated start.
  task automatic hr(input logic [7:0] a, input int cnt);
    logic [2:0] acks;
    u_host.start();
    u_host.send_byte({DEV_ADDR, 1'b0}, acks[2]);
    u_host.send_byte(a, acks[1]);
    u_host.start();
    u_host.send_byte({DEV_ADDR, 1'b1}, acks[0]);
    for (int i = 0; i < cnt; i++) begin
      u_host.recv_byte(i == cnt - 1, rdBuf[i]);
    end
    u_host.stop();
    check("read acks", {5'h00, acks}, 8'h00);
  endtask : hr

  ////////////////////////////////////////
  // Main sequence; reset held for 12 cycles, inputs move on falling edges.
  initial begin
    rst_n = 1'b0;
    monWrEn = 1'b0;
    monAddr = '0;
    monData = '0;
    repeat (11) @(negedge clk);
    check("reset irq", {7'h00, interruptRequestN}, 8'h01);
    check("reset sda", {6'h00, sdaOut, sdaOe}, 8'h00);
    check("reset ready", {7'h00, monReady}, 8'h00);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check("ready", {7'h00, monReady}, 8'h01);
    // Read-only bytes keep the module's value despite host writes.
    foreach (roAddr[i]) begin
      mon_wr(roAddr[i][9:0], roAddr[i][7:0] ^ 8'h5A);
      hw(roAddr[i][7:0], 8'hFF);
      hr(roAddr[i][7:0], 1);
      check("read-only", rdBuf[0], roAddr[i][7:0] ^ 8'h5A);
    end
    // The first and last byte of each writable lower area first, then read back to catch aliasing.
    foreach (rwAddr[i]) hw(rwAddr[i][7:0], rwAddr[i][7:0] ^ 8'hA5);
    foreach (rwAddr[i]) begin
      hr(rwAddr[i][7:0], 1);
      check("rw byte", rdBuf[0], rwAddr[i][7:0] ^ 8'hA5);
    end
    // Page select picks the upper page; the lower page stays visible.
    hr(PAGE_SEL_ADDR, 1);
    check("page reset", rdBuf[0], 8'h00);
    mon_wr(10'h080, 8'h11);
    mon_wr(10'h100, 8'h22);
    hw(PAGE_SEL_ADDR, 8'h01);
    hr(8'h80, 1);
    check("page 1", rdBuf[0], 8'h22);
    hr(8'h00, 1);
    check("lower page", rdBuf[0], 8'h5A);
    hw(PAGE_SEL_ADDR, 8'h00);
    hr(8'h80, 1);
    check("page 0", rdBuf[0], 8'h11);
    // Page 3 is the only upper page with host-writable bytes, from 226 up.
    hw(PAGE_SEL_ADDR, 8'h03);
    mon_wr(10'h261, 8'h3C);
    hw(8'hE1, 8'hC3);
    hw(8'hE2, 8'h96);
    hr(8'hE1, 2);
    check("page 3 ro", rdBuf[0], 8'h3C);
    check("page 3 rw", rdBuf[1], 8'h96);
    hw(PAGE_SEL_ADDR, 8'h00);
    // Check code over page-0 bytes 128..190, after the scan has caught up.
    sum = 8'h00;
    for (int k = 0; k < 63; k++) begin
      mon_wr(10'h080 + k[9:0], k[7:0] * 8'h03 + 8'h07);
      sum = sum + k[7:0] * 8'h03 + 8'h07;
    end
    repeat (300) @(negedge clk);
    hr(8'hBF, 1);
    check("check code", rdBuf[0], sum);
    // A foreign device address is not acknowledged.
    u_host.start();
    u_host.send_byte(8'hA2, ack);
    u_host.stop();
    check("foreign nack", {7'h00, ack}, 8'h01);
    // Flags pull the interrupt, one read collects and clears them.
    mon_wr(10'h005, 8'h04);
    mon_wr(10'h015, 8'h80);
    n = 0;
    while (interruptRequestN !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("irq set", {7'h00, interruptRequestN}, 8'h00);
    hr(FLAG_FIRST, FLAG_COUNT);
    for (int i = 0; i < FLAG_COUNT; i++) begin
      expByte = (i == 2) ? 8'h04 : ((i == 18) ? 8'h80 : 8'h00);
      check("flag", rdBuf[i], expByte);
    end
    repeat (20) @(negedge clk);
    check("irq clear", {7'h00, interruptRequestN}, 8'h01);
    hr(8'h05, 1);
    check("flag cleared", rdBuf[0], 8'h00);
    end_of_test();
  end

endmodule : module_mgmt_memory_map_tb
